// *** include/imfp_pkg.sv ***
// Package: register map, field positions, vectors and timing for the interrupt block
package imfp_pkg;

  localparam logic [7:0] OFF_MCU_CTRL = 8'h35;
  localparam logic [7:0] OFF_TMR_FLAGS = 8'h38;
  localparam logic [7:0] OFF_GEN_FLAGS = 8'h3A;
  localparam logic [7:0] OFF_GEN_MASK = 8'h3B;
  localparam logic [7:0] OFF_TMR_MASK = 8'h39;
  localparam logic [7:0] OFF_CPU_STATUS = 8'h3F;

  localparam int BIT_EXT = 6;
  localparam int BIT_PCH = 5;
  localparam int BIT_CMPA = 6;
  localparam int BIT_T1OV = 2;
  localparam int BIT_T0OV = 1;
  localparam int BIT_PUD = 6;
  localparam int BIT_SE = 5;
  localparam int BIT_SMHI = 4;
  localparam int BIT_SMLO = 3;
  localparam int BIT_ISCHI = 1;
  localparam int BIT_ISCLO = 0;
  localparam int BIT_GIE = 7;

  localparam logic [7:0] MASK_GEN = 8'h60;
  localparam logic [7:0] MASK_TMR = 8'h46;
  localparam logic [7:0] MASK_MCU = 8'h7B;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  localparam logic [8:0] VEC_EXT = 9'h001;
  localparam logic [8:0] VEC_PCH = 9'h002;
  localparam logic [8:0] VEC_CMPA = 9'h003;
  localparam logic [8:0] VEC_T1OV = 9'h004;
  localparam logic [8:0] VEC_T0OV = 9'h005;

  localparam int RESP_CYCLES = 4;
  localparam int WAKE_EXTRA = 4;
  localparam logic [3:0] RESP_LOAD = 4'(RESP_CYCLES);
  localparam logic [3:0] WAKE_LOAD = 4'(RESP_CYCLES + WAKE_EXTRA);

  typedef enum logic [1:0] {
    SENSE_LOW = 2'b00,
    SENSE_ANY = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } imfp_sense_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SERVE = 2'b10
  } imfp_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } imfp_bus_type;

endpackage : imfp_pkg

// *** rtl/imfp_flag.sv ***
// Sticky flag: set wins over write-one or vector clear
module imfp_flag
  import imfp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule : imfp_flag

// *** rtl/imfp_sync.sv ***
// Two-flop synchroniser for one pin
module imfp_sync
  import imfp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : imfp_sync

// *** rtl/imfp_top.sv ***
// Interrupt mask, flag and pin-change logic with vectoring handshake
// Summary of operation
// - External request needs enable bit 6 and global
// - External interrupt vectors to address one
// - Activity on low five pins requests even when driven output
// - Pin change enable plus global vectors two
// - Reserved bits always read zero
// - External flag sets on edge, clears
// - Level sense holds external flag zero
// - Pin change flag sets, clears by vector/write
// - Compare enable bit 6 requests vector three
// - Timer one overflow enable requests vector four
// - Timer zero overflow enable requests vector five
// - Compare flag sets on match, clears
// - Timer one overflow flag sets, clears
// - Timer zero overflow flag sets, clears
// - Level mode requests while pin low
// - Low five pins always; sixth if input
// - Pin change flagged alongside other interrupts
// - Pins sampled by clock before detection
// - Pull-up disable bit turns off pull-ups
// - Sleep only when sleep enable set
// - Sense bits: low, any, falling, rising
// - Entry clears global, return sets it
// - Pending flags remembered, served by priority
// - At least four cycles, four more asleep
module imfp_top
  import imfp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic EXT_PIN,
  input wire logic [5:0] PORT_PINS,
  input wire logic PIN_SIX_IS_INPUT,
  input wire logic CMP_MATCH_A,
  input wire logic T1_OVERFLOW,
  input wire logic T0_OVERFLOW,
  input wire logic SLEEP_INSTR,
  input wire logic RETURN_FROM_IRQ,
  input wire logic INSTR_BOUNDARY,
  output logic IRQ_TAKE,
  output logic [8:0] IRQ_VECTOR,
  output logic GLOBAL_IE,
  output logic SLEEPING,
  output logic PULLUP_DISABLE,
  output logic [1:0] SLEEP_MODE
);

  ////////////////////////////////////////////////////////////////////////
  imfp_bus_type bus;
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  logic [7:0] gen_mask_q;
  logic [7:0] tmr_mask_q;
  logic [7:0] mcu_ctrl_q;
  logic gie_q;
  logic ext_flag, pch_flag, cmpa_flag, t1_flag, t0_flag;
  imfp_state_type state_q;
  logic [3:0] cnt_q;
  logic [8:0] vec_q;
  logic sleep_q;

  logic wr_gen_flags, wr_tmr_flags;
  assign wr_gen_flags = bus.wr && bus.addr == OFF_GEN_FLAGS;
  assign wr_tmr_flags = bus.wr && bus.addr == OFF_TMR_FLAGS;

  // Writable bits only; reserved positions never store
  always_ff @(posedge CLK) begin
    if (RST) begin
      gen_mask_q <= RESET_BYTE;
      tmr_mask_q <= RESET_BYTE;
      mcu_ctrl_q <= RESET_BYTE;
    end else if (bus.wr) begin
      if (bus.addr == OFF_GEN_MASK) begin
        gen_mask_q <= bus.wdata & MASK_GEN;
      end else if (bus.addr == OFF_TMR_MASK) begin
        tmr_mask_q <= bus.wdata & MASK_TMR;
      end else if (bus.addr == OFF_MCU_CTRL) begin
        mcu_ctrl_q <= bus.wdata & MASK_MCU;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling and edge detection
  logic ext_s, ext_prev_q;
  logic [5:0] pins_s, pins_prev_q;
  logic six_in_s;

  imfp_sync u_sync_ext (.clk(CLK), .rst(RST), .d(EXT_PIN), .q(ext_s));
  imfp_sync u_sync_six (.clk(CLK), .rst(RST), .d(PIN_SIX_IS_INPUT), .q(six_in_s));

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_pin
      imfp_sync u_sync (.clk(CLK), .rst(RST), .d(PORT_PINS[gi]), .q(pins_s[gi]));
    end
  endgenerate

  // Reset prev to high so an idle-high pin gives no false edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      ext_prev_q <= 1'b1;
      pins_prev_q <= 6'h3F;
    end else begin
      ext_prev_q <= ext_s;
      pins_prev_q <= pins_s;
    end
  end

  // Synchronisers leave reset at zero; ignore edges until they hold real pin values
  logic [1:0] arm_q;
  logic armed;
  assign armed = arm_q == 2'h3;
  always_ff @(posedge CLK) begin
    if (RST) begin
      arm_q <= 2'h0;
    end else if (!armed) begin
      arm_q <= arm_q + 2'h1;
    end
  end

  imfp_sense_type sense;
  assign sense = imfp_sense_type'({mcu_ctrl_q[BIT_ISCHI], mcu_ctrl_q[BIT_ISCLO]});

  logic ext_event, level_mode, level_req, pch_event;
  logic [5:0] pin_diff;
  always_comb begin
    level_mode = (sense == SENSE_LOW);
    ext_event = 1'b0;
    case (sense)
      SENSE_ANY: ext_event = armed && (ext_s ^ ext_prev_q);
      SENSE_FALL: ext_event = armed && ext_prev_q && !ext_s;
      SENSE_RISE: ext_event = armed && !ext_prev_q && ext_s;
      default: ext_event = 1'b0;
    endcase
    level_req = level_mode && !ext_s;
    pin_diff = pins_s ^ pins_prev_q;
    // Pin change counted regardless of other interrupts on same pin
    pch_event = armed && ((|pin_diff[4:0]) || (pin_diff[5] && six_in_s));
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags: vector entry or write-one clears, set takes priority
  logic take_ext, take_pch, take_cmpa, take_t1, take_t0;
  assign take_ext = state_q == ST_SERVE && vec_q == VEC_EXT;
  assign take_pch = state_q == ST_SERVE && vec_q == VEC_PCH;
  assign take_cmpa = state_q == ST_SERVE && vec_q == VEC_CMPA;
  assign take_t1 = state_q == ST_SERVE && vec_q == VEC_T1OV;
  assign take_t0 = state_q == ST_SERVE && vec_q == VEC_T0OV;

  imfp_flag u_ext (.clk(CLK), .rst(RST), .set(ext_event && !level_mode),
    .clr(take_ext || level_mode || (wr_gen_flags && bus.wdata[BIT_EXT])),
    .q(ext_flag));
  imfp_flag u_pch (.clk(CLK), .rst(RST), .set(pch_event),
    .clr(take_pch || (wr_gen_flags && bus.wdata[BIT_PCH])), .q(pch_flag));
  imfp_flag u_cmpa (.clk(CLK), .rst(RST), .set(CMP_MATCH_A),
    .clr(take_cmpa || (wr_tmr_flags && bus.wdata[BIT_CMPA])), .q(cmpa_flag));
  imfp_flag u_t1 (.clk(CLK), .rst(RST), .set(T1_OVERFLOW),
    .clr(take_t1 || (wr_tmr_flags && bus.wdata[BIT_T1OV])), .q(t1_flag));
  imfp_flag u_t0 (.clk(CLK), .rst(RST), .set(T0_OVERFLOW),
    .clr(take_t0 || (wr_tmr_flags && bus.wdata[BIT_T0OV])), .q(t0_flag));

  ////////////////////////////////////////////////////////////////////////
  // Request gating and priority
  logic [4:0] pend;
  logic any_pend;
  logic [8:0] pick;
  always_comb begin
    pend[0] = gen_mask_q[BIT_EXT] && (ext_flag || level_req);
    pend[1] = gen_mask_q[BIT_PCH] && pch_flag;
    pend[2] = tmr_mask_q[BIT_CMPA] && cmpa_flag;
    pend[3] = tmr_mask_q[BIT_T1OV] && t1_flag;
    pend[4] = tmr_mask_q[BIT_T0OV] && t0_flag;
    any_pend = |pend;
    // Lowest vector wins; flags stay pending while global is off
    if (pend[0]) pick = VEC_EXT;
    else if (pend[1]) pick = VEC_PCH;
    else if (pend[2]) pick = VEC_CMPA;
    else if (pend[3]) pick = VEC_T1OV;
    else pick = VEC_T0OV;
  end

  ////////////////////////////////////////////////////////////////////////
  // Vectoring sequence; priority is re-evaluated at the grant cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      vec_q <= 9'h000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (gie_q && any_pend && INSTR_BOUNDARY) begin
            state_q <= ST_WAIT;
            cnt_q <= sleep_q ? WAKE_LOAD - 4'h1 : RESP_LOAD - 4'h1;
          end
        end
        ST_WAIT: begin
          if (cnt_q == 4'h1) begin
            state_q <= ST_SERVE;
            vec_q <= pick;
          end
          cnt_q <= cnt_q - 4'h1;
        end
        ST_SERVE: begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Global bit: entry clears, return sets, software may write
  always_ff @(posedge CLK) begin
    if (RST) begin
      gie_q <= 1'b0;
    end else if (state_q == ST_IDLE && gie_q && any_pend && INSTR_BOUNDARY) begin
      gie_q <= 1'b0;
    end else if (RETURN_FROM_IRQ) begin
      gie_q <= 1'b1;
    end else if (bus.wr && bus.addr == OFF_CPU_STATUS) begin
      gie_q <= bus.wdata[BIT_GIE];
    end
  end

  // Sleep state: enter only with sleep enable; any pending enabled wake
  always_ff @(posedge CLK) begin
    if (RST) begin
      sleep_q <= 1'b0;
    end else if (sleep_q && any_pend) begin
      sleep_q <= 1'b0;
    end else if (SLEEP_INSTR && mcu_ctrl_q[BIT_SE]) begin
      sleep_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ_TAKE <= 1'b0;
      IRQ_VECTOR <= 9'h000;
      GLOBAL_IE <= 1'b0;
      SLEEPING <= 1'b0;
      PULLUP_DISABLE <= 1'b0;
      SLEEP_MODE <= 2'b00;
    end else begin
      IRQ_TAKE <= state_q == ST_WAIT && cnt_q == 4'h1;
      IRQ_VECTOR <= (state_q == ST_WAIT && cnt_q == 4'h1) ? pick : IRQ_VECTOR;
      GLOBAL_IE <= gie_q;
      SLEEPING <= sleep_q;
      PULLUP_DISABLE <= mcu_ctrl_q[BIT_PUD];
      SLEEP_MODE <= {mcu_ctrl_q[BIT_SMHI], mcu_ctrl_q[BIT_SMLO]};
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (bus.rd) begin
      if (bus.addr == OFF_GEN_MASK) RDATA <= gen_mask_q;
      else if (bus.addr == OFF_TMR_MASK) RDATA <= tmr_mask_q;
      else if (bus.addr == OFF_MCU_CTRL) RDATA <= mcu_ctrl_q;
      else if (bus.addr == OFF_GEN_FLAGS) RDATA <= {1'b0, ext_flag, pch_flag, 5'h00};
      else if (bus.addr == OFF_TMR_FLAGS) RDATA <= {1'b0, cmpa_flag, 3'h0, t1_flag, t0_flag, 1'b0};
      else if (bus.addr == OFF_CPU_STATUS) RDATA <= {gie_q, 7'h00};
      else RDATA <= 8'h00;
    end else begin
      RDATA <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_gie_entry: assert property (@(posedge CLK) disable iff (RST)
    (state_q == ST_IDLE && gie_q && any_pend && INSTR_BOUNDARY && !RETURN_FROM_IRQ)
      |=> !gie_q) else $error("global bit not cleared on entry");
  a_resp_min: assert property (@(posedge CLK) disable iff (RST)
    (state_q == ST_IDLE && gie_q && any_pend && INSTR_BOUNDARY && !sleep_q)
      |=> !IRQ_TAKE [*3] ##1 IRQ_TAKE) else $error("response not four cycles");
  a_level_noflag: assert property (@(posedge CLK) disable iff (RST)
    level_mode |=> !ext_flag || !$past(level_mode)) else $error("flag in level mode");
  a_set_wins: assert property (@(posedge CLK) disable iff (RST)
    (T0_OVERFLOW && wr_tmr_flags && bus.wdata[BIT_T0OV]) |=> t0_flag)
    else $error("set lost to clear");
  a_ext_vector: assert property (@(posedge CLK) disable iff (RST)
    (IRQ_TAKE && $past(pend[0])) |-> IRQ_VECTOR == VEC_EXT)
    else $error("wrong priority");
  a_sleep_gate: assert property (@(posedge CLK) disable iff (RST)
    $rose(sleep_q) |-> $past(mcu_ctrl_q[BIT_SE])) else $error("slept without enable");
  a_pch_set: assert property (@(posedge CLK) disable iff (RST)
    (armed && (|pin_diff[4:0])) |=> pch_flag) else $error("pin change missed");
  a_tmr_read: assert property (@(posedge CLK) disable iff (RST)
    (bus.rd && bus.addr == OFF_TMR_FLAGS) |=> RDATA[0] == 1'b0 && RDATA[5:3] == 3'h0)
    else $error("reserved bits nonzero");
  a_cmpa_clear: assert property (@(posedge CLK) disable iff (RST)
    (take_cmpa && !CMP_MATCH_A) |=> !cmpa_flag) else $error("compare flag kept");

endmodule : imfp_top

// *** verif/imfp_core_model.sv ***
// Core-side partner: instruction boundaries, vector log and interrupt return
module imfp_core_model
  import imfp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic irq_take,
  input wire logic [8:0] irq_vector,
  input wire logic global_ie,
  output logic instr_boundary,
  output logic return_from_irq
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [9:0] log_q[$];
  int gap_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      instr_boundary <= 1'b0;
      return_from_irq <= 1'b0;
      gap_q <= 0;
    end else begin
      // A slow core busy with multi-cycle work offers every other cycle only
      instr_boundary <= slow ? ~instr_boundary : 1'b1;
      return_from_irq <= (gap_q == 1);
      if (irq_take) begin
        log_q.push_back({global_ie, irq_vector});
        gap_q <= slow ? 12 : 3;
      end else if (gap_q > 0) begin
        gap_q <= gap_q - 1;
      end
    end
  end
endmodule : imfp_core_model

// *** verif/imfp_top_tb_top.sv ***
// Self-checking bench for the interrupt mask, flag and pin-change block
module imfp_top_tb_top
  import imfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } imfp_row_type;
  localparam imfp_row_type ROWS [9] = '{
    '{OFF_MCU_CTRL, 8'hFF, 8'h7B}, '{OFF_GEN_MASK, 8'hFF, 8'h60},
    '{OFF_TMR_MASK, 8'hFF, 8'h46}, '{OFF_GEN_FLAGS, 8'hFF, 8'h00},
    '{OFF_TMR_FLAGS, 8'hFF, 8'h00}, '{8'h20, 8'hFF, 8'h00},
    '{OFF_GEN_MASK, 8'h00, 8'h00}, '{OFF_TMR_MASK, 8'h00, 8'h00},
    '{OFF_MCU_CTRL, 8'h40, 8'h40}};
  localparam logic [8:0] VEXP [3] = '{VEC_CMPA, VEC_T1OV, VEC_T0OV};

  logic clk = 1'b0;
  logic rst = 1'b1;
  imfp_bus_type bus = '0;
  logic ext_pin = 1'b1;
  logic six_in = 1'b0;
  logic sleep_i = 1'b0;
  logic slow = 1'b0;
  logic [5:0] pins = 6'h3F;
  logic [2:0] ev = 3'h0;
  logic [7:0] rdata;
  logic [8:0] vec;
  logic [1:0] smode;
  logic take, gie, sleeping, pullup_disable, ib, ret;
  int n_fail = 0;
  int n_tests = 0;
  int ls, la, lat;

  initial begin
    forever #2.5 clk = ~clk;
  end

  imfp_top u_dut (.CLK(clk), .RST(rst), .ADDR(bus.addr), .WDATA(bus.wdata), .WR(bus.wr),
    .RD(bus.rd), .RDATA(rdata), .EXT_PIN(ext_pin), .PORT_PINS(pins),
    .PIN_SIX_IS_INPUT(six_in), .CMP_MATCH_A(ev[2]), .T1_OVERFLOW(ev[1]),
    .T0_OVERFLOW(ev[0]), .SLEEP_INSTR(sleep_i), .RETURN_FROM_IRQ(ret),
    .INSTR_BOUNDARY(ib), .IRQ_TAKE(take), .IRQ_VECTOR(vec), .GLOBAL_IE(gie),
    .SLEEPING(sleeping), .PULLUP_DISABLE(pullup_disable), .SLEEP_MODE(smode));

  imfp_core_model u_core (.clk(clk), .rst(rst), .slow(slow), .irq_take(take),
    .irq_vector(vec), .global_ie(gie), .instr_boundary(ib), .return_from_irq(ret));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk({2'b00, rdata}, {2'b00, e});
  endtask : rd_chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle

  task automatic ev_pulse(input logic [2:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= 3'h0;
  endtask : ev_pulse

  task automatic sleep_pulse;
    @(posedge clk) sleep_i <= 1'b1;
    @(posedge clk) sleep_i <= 1'b0;
    settle(2);
  endtask : sleep_pulse

  // Bounded wait so a missing grant cannot hang the run
  task automatic wait_take(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (take !== 1'b1 && n < 200);
    chk(10'(n < 200), 10'h001);
  endtask : wait_take

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd_chk(ROWS[i].addr, RESET_BYTE);
    for (int i = 0; i < 9; i++) begin
      wr_reg(ROWS[i].addr, ROWS[i].wdata);
      rd_chk(ROWS[i].addr, ROWS[i].exp);
    end
    chk(10'({pullup_disable, smode}), 10'h004);
    for (int m = 1; m < 4; m++) begin
      wr_reg(OFF_MCU_CTRL, 8'(m));
      wr_reg(OFF_GEN_FLAGS, MASK_GEN);
      @(posedge clk) ext_pin <= 1'b0;
      settle(6);
      rd_chk(OFF_GEN_FLAGS, (m != 3) ? 8'h40 : 8'h00);
      wr_reg(OFF_GEN_FLAGS, MASK_GEN);
      @(posedge clk) ext_pin <= 1'b1;
      settle(6);
      rd_chk(OFF_GEN_FLAGS, (m != 2) ? 8'h40 : 8'h00);
    end
    // Level sense: requests repeat while low, flag stays clear
    wr_reg(OFF_MCU_CTRL, 8'h00);
    @(posedge clk) ext_pin <= 1'b0;
    settle(6);
    rd_chk(OFF_GEN_FLAGS, 8'h00);
    wr_reg(OFF_GEN_MASK, 8'h40);
    wr_reg(OFF_CPU_STATUS, 8'h80);
    wait_take(lat);
    wait_take(lat);
    wr_reg(OFF_GEN_MASK, 8'h00);
    @(posedge clk) ext_pin <= 1'b1;
    settle(30);
    foreach (u_core.log_q[i]) chk(u_core.log_q[i], {1'b0, VEC_EXT});
    chk(10'(gie), 10'h001);
    u_core.log_q.delete();
    @(posedge clk) pins[5] <= ~pins[5];
    settle(6);
    rd_chk(OFF_GEN_FLAGS, 8'h00);
    @(posedge clk) six_in <= 1'b1;
    settle(4);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk) pins[k] <= ~pins[k];
      settle(2);
      pins[k] <= ~pins[k];
      settle(6);
      rd_chk(OFF_GEN_FLAGS, 8'h20);
      wr_reg(OFF_GEN_FLAGS, 8'h20);
    end
    wr_reg(OFF_GEN_MASK, 8'h20);
    @(posedge clk) pins[0] <= ~pins[0];
    wait_take(lat);
    chk({1'b0, vec}, {1'b0, VEC_PCH});
    settle(10);
    rd_chk(OFF_GEN_FLAGS, 8'h00);
    wr_reg(OFF_GEN_MASK, 8'h00);
    u_core.log_q.delete();
    // Flags pile up while disabled, then drain by vector order on a slow core
    wr_reg(OFF_CPU_STATUS, 8'h00);
    slow <= 1'b1;
    ev_pulse(3'b111);
    rd_chk(OFF_TMR_FLAGS, MASK_TMR);
    wr_reg(OFF_TMR_MASK, MASK_TMR);
    wr_reg(OFF_CPU_STATUS, 8'h80);
    settle(90);
    chk(10'(u_core.log_q.size()), 10'h003);
    for (int i = 0; i < 3; i++) chk(u_core.log_q[i], {1'b0, VEXP[i]});
    rd_chk(OFF_TMR_FLAGS, 8'h00);
    wr_reg(OFF_CPU_STATUS, 8'h00);
    slow <= 1'b0;
    @(posedge clk);
    ev <= 3'b001;
    bus.addr <= OFF_TMR_FLAGS;
    bus.wdata <= 8'h02;
    bus.wr <= 1'b1;
    @(posedge clk);
    ev <= 3'h0;
    bus.wr <= 1'b0;
    rd_chk(OFF_TMR_FLAGS, 8'h02);
    wr_reg(OFF_TMR_FLAGS, 8'h02);
    rd_chk(OFF_TMR_FLAGS, 8'h00);
    sleep_pulse();
    chk(10'(sleeping), 10'h000);
    wr_reg(OFF_MCU_CTRL, 8'h20);
    sleep_pulse();
    chk(10'(sleeping), 10'h001);
    wr_reg(OFF_CPU_STATUS, 8'h80);
    ev_pulse(3'b001);
    wait_take(ls);
    settle(20);
    ev_pulse(3'b001);
    wait_take(la);
    chk(10'(ls - la), 10'h004);
    chk(10'(la >= 4), 10'h001);
    settle(10);
    test_done();
  end
endmodule : imfp_top_tb_top
